// ==== inc/ptc32_pkg.sv ====
// Purpose: shared constants and carrier types of the paged translation checker
// Assumes: 32-bit virtual addresses, 34-bit physical addresses, 4-byte table entries
// Notes:   register offsets are byte addresses on a 32-bit APB slave
package ptc32_pkg;
   // ==========================================================================
   // address geometry
   localparam int PTC_VA_W   = 32;
   localparam int PTC_PA_W   = 34;
   localparam int PTC_PPN_W  = 22;
   localparam int PTC_OFS_W  = 12;
   localparam int PTC_IDX1_LO = 22;
   localparam int PTC_IDX0_LO = 12;
   localparam int PTC_APB_AW = 12;

   // ==========================================================================
   // table entry layout
   localparam int PTE_V       = 0;
   localparam int PTE_R       = 1;
   localparam int PTE_W       = 2;
   localparam int PTE_X       = 3;
   localparam int PTE_U       = 4;
   localparam int PTE_G       = 5;
   localparam int PTE_A       = 6;
   localparam int PTE_D       = 7;
   localparam int PTE_PPN_LO  = 10;
   localparam int PTE_PPN1_LO = 20;
   localparam logic [31:0] PTE_A_MASK = 32'h0000_0040;
   localparam logic [31:0] PTE_D_MASK = 32'h0000_0080;

   // ==========================================================================
   // register map
   localparam logic [11:0] REG_CTRL     = 12'h000;
   localparam logic [11:0] REG_ROOT     = 12'h004;
   localparam logic [11:0] REG_STATUS   = 12'h008;
   localparam logic [11:0] REG_FAULT_VA = 12'h00C;
   localparam int CTRL_PAGED_BIT  = 0;
   localparam int CTRL_PERMIT_BIT = 1;
   localparam int CTRL_HWAD_BIT   = 2;
   localparam logic        CTRL_PAGED_RST  = 1'b0;
   localparam logic        CTRL_PERMIT_RST = 1'b0;
   localparam logic        CTRL_HWAD_RST   = 1'b0;
   localparam logic [21:0] ROOT_RST        = 22'h00_0000;

   // ==========================================================================
   // carriers
   typedef enum logic [2:0] {ACC_FETCH, ACC_LOAD, ACC_LOAD_RSV, ACC_STORE, ACC_STORE_COND, ACC_AMO} ptc_acc_t;
   typedef enum logic [1:0] {PRIV_U, PRIV_S, PRIV_M} ptc_priv_t;
   typedef enum logic [1:0] {FLT_NONE, FLT_FETCH, FLT_LOAD, FLT_STORE} ptc_fault_t;

   typedef struct packed {
      logic [31:0] vaddr;
      ptc_acc_t    acc;
      ptc_priv_t   priv;
      logic        spec;
   } ptc_req_t;

   typedef struct packed {
      logic [33:0] paddr;
      ptc_fault_t  fault;
      logic        global_map;
      logic        spec_blocked;
      logic        rsv_hit;
   } ptc_rsp_t;

   typedef struct packed {
      logic [33:0] addr;
      logic        write;
      logic [31:0] wdata;
      logic [31:0] cmp;
   } ptc_mem_req_t;
endpackage

// ==== core/ptc32_top.sv ====
// Purpose: two-level page walker and permission checker for the paged 32-bit scheme
// Assumes: one request in flight; page-table memory answers with mem_ack and a compare result
// Notes:   no translation cache; every translated request walks from the root
// Function
// - split address into 20-bit page number, 12-bit offset
// - walk two levels when paged scheme selected, except for machine-mode requests
// - 1024 four-byte entries, root from root register
// - zero-extend physical address to machine width
// - translation off passes address, zero-extended
// - invalid entry ends walk in fault
// - rwx zero means pointer, else leaf
// - invalid, write-only or reserved bits fault
// - pointer at last level faults
// - fetch needs execute permission
// - load and reserved load need read
// - stores and atomics need write, never load fault
// - user needs user bit; supervisor needs permit
// - supervisor never fetches from user page
// - global pointer makes lower mappings global
// - software field is ignored
// - fault scheme: missing accessed/dirty faults
// - hardware scheme sets bits by atomic compare
// - dirty set only for non-speculative stores
// - answer only after entry update is done
// - accessed and dirty bits never cleared
// - first-level leaf is megapage, must align
// - pointer dirty/accessed/user bits are reserved
// - megapage low segment comes from address
// - reservation set is one 4 KiB page
`timescale 1ns/10ps
module ptc32_top
   import ptc32_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    req_valid,
   output logic                         req_ready,
   input  wire ptc32_pkg::ptc_req_t     req,
   output logic                         rsp_valid,
   output ptc32_pkg::ptc_rsp_t          rsp,
   output logic                         mem_req_valid,
   output ptc32_pkg::ptc_mem_req_t      mem_req,
   input  wire logic                    mem_ack,
   input  wire logic [31:0]             mem_rdata,
   input  wire logic                    mem_cas_fail
);
   import ptc32_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_CHECK, ST_UPDATE, ST_DONE} ptc_state_t;

   ptc_state_t  state;
   ptc_state_t  next_state;
   ptc_req_t    req_q;
   logic        lvl;
   logic [31:0] pte_q;
   logic        g_acc;
   ptc_rsp_t    rsp_q;
   logic        paged_en;
   logic        permit;
   logic        hwad;
   logic [21:0] root_ppn;
   logic        rsv_valid;
   logic [21:0] rsv_ppn;
   logic [15:0] fault_count;
   ptc_fault_t  last_fault;
   logic [31:0] fault_va;
   logic [31:0] prdata_q;
   ptc_mem_req_t mem_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   function automatic logic acc_is_write(input ptc_acc_t a);
      return (a == ACC_STORE) || (a == ACC_STORE_COND) || (a == ACC_AMO);
   endfunction

   function automatic ptc_fault_t fault_of(input ptc_acc_t a);
      if (a == ACC_FETCH) begin
         return FLT_FETCH;
      end else if (acc_is_write(a)) begin
         return FLT_STORE;   // atomics land here, never as load faults
      end
      return FLT_LOAD;
   endfunction

   // ==========================================================================
   // entry decode; software field bits 9:8 are never looked at
   logic        e_v, e_r, e_w, e_x, e_u, e_g, e_a, e_d;
   logic        e_ptr;
   logic        e_bad;
   logic        perm_ok;
   logic        priv_ok;
   logic        mega_mis;
   logic        need_a;
   logic        need_d;
   logic        chk_fault;
   logic        chk_blocked;
   logic        chk_update;
   logic [33:0] chk_paddr;
   logic        bare_now;
   logic [33:0] cand_paddr;
   logic        rsv_hit_now;

   assign e_v = pte_q[PTE_V];
   assign e_r = pte_q[PTE_R];
   assign e_w = pte_q[PTE_W];
   assign e_x = pte_q[PTE_X];
   assign e_u = pte_q[PTE_U];
   assign e_g = pte_q[PTE_G];
   assign e_a = pte_q[PTE_A];
   assign e_d = pte_q[PTE_D];
   assign e_ptr = !e_r && !e_w && !e_x;
   // reserved pointer bits and write-without-read count as malformed
   assign e_bad = !e_v || (e_w && !e_r) || (e_ptr && (e_d || e_a || e_u));

   always_comb begin
      perm_ok = 1'b0;
      case (req_q.acc)
         ACC_FETCH:                 perm_ok = e_x;
         ACC_LOAD, ACC_LOAD_RSV:    perm_ok = e_r;
         default:                   perm_ok = e_w;
      endcase
   end

   always_comb begin
      if (req_q.priv == PRIV_U) begin
         priv_ok = e_u;
      end else if (e_u) begin
         priv_ok = permit && (req_q.acc != ACC_FETCH);
      end else begin
         priv_ok = 1'b1;
      end
   end

   assign mega_mis = lvl && (pte_q[PTE_PPN1_LO-1:PTE_PPN_LO] != 10'h000);
   assign need_a = !e_a;
   assign need_d = acc_is_write(req_q.acc) && !e_d;
   assign chk_fault = e_bad || (e_ptr && !lvl) || (!e_ptr && (!perm_ok || !priv_ok || mega_mis))
                      || (!e_ptr && (need_a || need_d) && !hwad);
   // with hwad set, a speculative store may not mark the page dirty, so it stops without a fault
   assign chk_blocked = !chk_fault && !e_ptr && need_d && req_q.spec;
   assign chk_update = !chk_fault && !chk_blocked && !e_ptr && (need_a || need_d);

   always_comb begin
      if (lvl) begin
         chk_paddr = {pte_q[31:PTE_PPN1_LO], req_q.vaddr[PTC_IDX1_LO-1:0]};
      end else begin
         chk_paddr = {pte_q[31:PTE_PPN_LO], req_q.vaddr[PTC_OFS_W-1:0]};
      end
   end

   assign bare_now = !paged_en || (req.priv == PRIV_M);
   assign cand_paddr = (state == ST_IDLE) ? {2'b00, req.vaddr} : chk_paddr;
   assign rsv_hit_now = rsv_valid && (rsv_ppn == cand_paddr[33:PTC_OFS_W]);

   // ==========================================================================
   // walk sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_state = bare_now ? ST_DONE : ST_READ;
            end
         end
         ST_READ: begin
            if (mem_ack) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (chk_fault || chk_blocked) begin
               next_state = ST_DONE;
            end else if (e_ptr) begin
               next_state = ST_READ;
            end else if (chk_update) begin
               next_state = ST_UPDATE;
            end else begin
               next_state = ST_DONE;
            end
         end
         ST_UPDATE: begin
            if (mem_ack) begin
               // entry changed under us: reread it and check it again
               next_state = mem_cas_fail ? ST_READ : ST_DONE;
            end
         end
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
         lvl   <= 1'b1;
         g_acc <= 1'b0;
         pte_q <= 32'h0000_0000;
      end else begin
         if (state == ST_IDLE && req_valid) begin
            req_q <= req;
            lvl   <= 1'b1;
            g_acc <= 1'b0;
         end
         if ((state == ST_READ) && mem_ack) begin
            pte_q <= mem_rdata;
         end
         if (state == ST_CHECK && !chk_fault && e_ptr) begin
            lvl   <= 1'b0;
            g_acc <= g_acc | e_g;
         end
      end
   end

   // ==========================================================================
   // page-table memory port
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_q <= '0;
      end else begin
         if (state == ST_IDLE && req_valid && !bare_now) begin
            mem_q.addr  <= {root_ppn, req.vaddr[31:PTC_IDX1_LO], 2'b00};
            mem_q.write <= 1'b0;
         end else if (state == ST_CHECK && !chk_fault && e_ptr && lvl) begin
            mem_q.addr  <= {pte_q[31:PTE_PPN_LO], req_q.vaddr[PTC_IDX1_LO-1:PTC_IDX0_LO], 2'b00};
            mem_q.write <= 1'b0;
         end else if (state == ST_CHECK && chk_update) begin
            mem_q.write <= 1'b1;
            mem_q.cmp   <= pte_q;
            // only ever or-in bits, so software alone clears them
            mem_q.wdata <= pte_q | PTE_A_MASK | (need_d ? PTE_D_MASK : 32'h0000_0000);
         end else if (state == ST_UPDATE && mem_ack) begin
            mem_q.write <= 1'b0;
         end
      end
   end

   assign mem_req_valid = (state == ST_READ) || (state == ST_UPDATE);
   assign mem_req = mem_q;

   // ==========================================================================
   // answer to the pipeline
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rsp_q <= '0;
      end else if (state == ST_IDLE && req_valid && bare_now) begin
         rsp_q.paddr        <= cand_paddr;
         rsp_q.fault        <= FLT_NONE;
         rsp_q.global_map   <= 1'b0;
         rsp_q.spec_blocked <= 1'b0;
         rsp_q.rsv_hit      <= rsv_hit_now && (req.acc == ACC_STORE_COND);
      end else if (state == ST_CHECK && (chk_fault || chk_blocked || !e_ptr)) begin
         rsp_q.paddr        <= (chk_fault || chk_blocked) ? 34'h0_0000_0000 : chk_paddr;
         rsp_q.fault        <= chk_fault ? fault_of(req_q.acc) : FLT_NONE;
         rsp_q.global_map   <= g_acc | e_g;
         rsp_q.spec_blocked <= chk_blocked;
         rsp_q.rsv_hit      <= rsv_hit_now && (req_q.acc == ACC_STORE_COND) && !chk_fault;
      end
   end

   assign req_ready = (state == ST_IDLE);
   assign rsp_valid = (state == ST_DONE);
   assign rsp = rsp_q;

   // a reservation covers the whole naturally aligned page
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rsv_valid <= 1'b0;
         rsv_ppn   <= 22'h00_0000;
      end else if (state == ST_DONE && rsp_q.fault == FLT_NONE && !rsp_q.spec_blocked) begin
         if (req_q.acc == ACC_LOAD_RSV) begin
            rsv_valid <= 1'b1;
            rsv_ppn   <= rsp_q.paddr[33:PTC_OFS_W];
         end else if (req_q.acc == ACC_STORE_COND) begin
            rsv_valid <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // fault bookkeeping visible to software
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_count <= 16'h0000;
         last_fault  <= FLT_NONE;
         fault_va    <= 32'h0000_0000;
      end else if (state == ST_DONE && rsp_q.fault != FLT_NONE) begin
         fault_count <= fault_count + 16'h0001;
         last_fault  <= rsp_q.fault;
         fault_va    <= req_q.vaddr;
      end
   end

   // ==========================================================================
   // APB slave, zero wait states, read data captured in the setup cycle
   logic apb_setup;
   logic apb_access;
   logic apb_mapped;

   assign apb_setup  = psel && !penable;
   assign apb_access = psel && penable;
   assign apb_mapped = (paddr == REG_CTRL) || (paddr == REG_ROOT) || (paddr == REG_STATUS)
                       || (paddr == REG_FAULT_VA);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         paged_en <= CTRL_PAGED_RST;
         permit   <= CTRL_PERMIT_RST;
         hwad     <= CTRL_HWAD_RST;
         root_ppn <= ROOT_RST;
      end else if (apb_access && pwrite) begin
         // mode changes apply to the next request taken; permit and hwad are read when the entry is checked
         if (paddr == REG_CTRL) begin
            paged_en <= pwdata[CTRL_PAGED_BIT];
            permit   <= pwdata[CTRL_PERMIT_BIT];
            hwad     <= pwdata[CTRL_HWAD_BIT];
         end
         if (paddr == REG_ROOT) begin
            root_ppn <= pwdata[PTC_PPN_W-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (apb_setup) begin
         case (paddr)
            REG_CTRL:     prdata_q <= {29'h0000_0000, hwad, permit, paged_en};
            REG_ROOT:     prdata_q <= {10'h000, root_ppn};
            REG_STATUS:   prdata_q <= {fault_count, 10'h000, rsv_valid, last_fault, lvl,
                                       g_acc, (state != ST_IDLE)};
            REG_FAULT_VA: prdata_q <= fault_va;
            default:      prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = apb_access && !apb_mapped;

   // ==========================================================================
   // checks
   sequence s_update_ok;
      (state == ST_UPDATE) && mem_ack && !mem_cas_fail;
   endsequence

   sequence s_leaf_check;
      (state == ST_CHECK) && !e_bad && !e_ptr;
   endsequence

   a_bare_passthru: assert property ((state == ST_IDLE) && req_valid && bare_now |=> ##0 rsp_valid ##0
      (rsp.paddr == {2'b00, req_q.vaddr}))
      else $error("bare address not passed through");
   a_offset_kept: assert property (rsp_valid && (rsp.fault == FLT_NONE) && !rsp.spec_blocked |->
      (rsp.paddr[PTC_OFS_W-1:0] == req_q.vaddr[PTC_OFS_W-1:0]))
      else $error("page offset altered");
   a_walk_root: assert property ((state == ST_IDLE) && req_valid && !bare_now |=>
      (mem_req_valid && (mem_req.addr == {$past(root_ppn), req_q.vaddr[31:PTC_IDX1_LO], 2'b00})))
      else $error("root entry address wrong");
   a_ad_only_set: assert property (mem_req_valid && mem_req.write |->
      ((mem_req.wdata & mem_req.cmp) == mem_req.cmp) && mem_req.wdata[PTE_A])
      else $error("entry update clears bits");
   a_dirty_exact: assert property (mem_req_valid && mem_req.write && mem_req.wdata[PTE_D] && !mem_req.cmp[PTE_D]
      |-> !req_q.spec && acc_is_write(req_q.acc))
      else $error("dirty set without committed store");
   a_update_answer: assert property (s_update_ok |=> rsp_valid ##1 !rsp_valid)
      else $error("answer not after update");
   a_invalid_fault: assert property ((state == ST_CHECK) && !e_v |=> rsp_valid && (rsp.fault != FLT_NONE))
      else $error("invalid entry did not fault");
   a_user_fetch: assert property (s_leaf_check ##0 e_u && (req_q.priv == PRIV_S) && (req_q.acc == ACC_FETCH)
      |=> rsp_valid && (rsp.fault == FLT_FETCH))
      else $error("supervisor fetched user page");
   a_amo_no_load: assert property (rsp_valid && (req_q.acc == ACC_AMO) |-> (rsp.fault != FLT_LOAD))
      else $error("atomic raised load fault");
   a_mega_align: assert property (s_leaf_check ##0 lvl && (pte_q[PTE_PPN1_LO-1:PTE_PPN_LO] != 10'h000)
      |=> rsp_valid && (rsp.fault != FLT_NONE))
      else $error("misaligned megapage accepted");
   a_fault_scheme: assert property (s_leaf_check ##0 !e_a && !hwad |=> rsp_valid && (rsp.fault != FLT_NONE))
      else $error("missing accessed bit not faulted");
   a_last_ptr: assert property ((state == ST_CHECK) && e_v && e_ptr && !lvl |=> rsp_valid
      && (rsp.fault == $past(fault_of(req_q.acc))))
      else $error("pointer at last level not faulted");
endmodule

// ==== testbench/ptc32_mem_model.sv ====
// Purpose: page-table memory standing behind the walker
// Assumes: one entry request at a time, held until mem_ack
// Notes:   lat slows answers; fail_once refuses the next swap
`timescale 1ns/10ps
module ptc32_mem_model
   import ptc32_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    mem_req_valid,
   input  wire ptc32_pkg::ptc_mem_req_t mem_req,
   output logic                         mem_ack,
   output logic [31:0]                  mem_rdata,
   output logic                         mem_cas_fail
);
   // ====================
   // storage and answer
   logic [31:0] mem [logic [33:0]];
   int          lat       = 0;
   int          cnt;
   logic        fail_once = 1'b0;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_ack      <= 1'b0;
         mem_cas_fail <= 1'b0;
         mem_rdata    <= 32'h0000_0000;
         cnt          <= 0;
      end else if (mem_req_valid && !mem_ack && cnt >= lat) begin
         mem_ack <= 1'b1;
         cnt     <= 0;
         if (!mem_req.write) begin
            mem_rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : 32'h0000_0000;
         end else if (mem[mem_req.addr] === mem_req.cmp && !fail_once) begin
            mem[mem_req.addr] = mem_req.wdata;
            mem_cas_fail <= 1'b0;
         end else begin
            mem_cas_fail <= 1'b1;
            fail_once = 1'b0;
         end
      end else begin
         // released data toggles so a stale word never looks valid
         mem_ack      <= 1'b0;
         mem_cas_fail <= 1'b0;
         mem_rdata    <= ~mem_rdata;
         cnt          <= (mem_req_valid && !mem_ack) ? cnt + 1 : 0;
      end
   end
endmodule

// ==== testbench/paged_translation_checker_32_tb.sv ====
// Purpose: self-checking bench of the page walker
// Assumes: tables live in the memory model, root page 0x100
// Notes:   bench waits for every response before the next request
`timescale 1ns/10ps
module paged_translation_checker_32_tb;
   import ptc32_pkg::*;
   // ====================
   // stimulus and wiring
   localparam logic [31:0] VA4K = 32'h0040_1ABC;
   localparam logic [33:0] PA4K = {22'h3ABCD, 12'hABC};
   localparam logic [33:0] L1A  = 34'h10_0004;
   localparam logic [33:0] L2A  = 34'h20_0004;
   logic           sys_clk = 1'b0;
   logic           rst     = 1'b1;
   logic           psel    = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite  = 1'b0;
   logic [11:0]    paddr   = 12'h000;
   logic [31:0]    pwdata  = 32'h0000_0000;
   logic           req_valid = 1'b0;
   ptc_req_t       req     = '0;
   logic [31:0]    prdata, mem_rdata;
   logic           pready, pslverr, req_ready, rsp_valid, mem_req_valid, mem_ack, mem_cas_fail;
   ptc_rsp_t       rsp;
   ptc_mem_req_t   mem_req;
   logic [7:0]     flg [8] = '{8'hDF, 8'hCB, 8'hC5, 8'h4F, 8'h8F, 8'hCE, 8'hC3, 8'hD9};
   int             error_cnt = 0;
   int             tests_run = 0;
   int             flt_cnt   = 0;

   always #50 sys_clk = ~sys_clk;

   ptc32_top u_ptc32_top (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .req_valid, .req_ready, .req, .rsp_valid, .rsp, .mem_req_valid, .mem_req, .mem_ack,
      .mem_rdata, .mem_cas_fail);
   ptc32_mem_model u_ptc32_mem_model (.sys_clk, .rst, .mem_req_valid, .mem_req, .mem_ack, .mem_rdata,
      .mem_cas_fail);

   // ====================
   // shared tasks
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic ee);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk(pready === 1'b1 && pslverr === ee && (w || prdata === e), "register access");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic xl(input logic [31:0] va, input ptc_acc_t a, input ptc_priv_t p, input logic sp,
                     input logic [33:0] ep, input ptc_fault_t ef);
      int n;
      n = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req       <= '{va, a, p, sp};
      do begin
         @(posedge sys_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 300);
      chk(rsp_valid === 1'b1 && rsp.paddr === ep && rsp.fault === ef, "translation result");
      if (ef != FLT_NONE) begin
         flt_cnt++;
      end
   endtask

   function automatic logic [31:0] pte(input logic [21:0] ppn, input logic [7:0] f);
      return {ppn, 2'b11, f};
   endfunction

   // fault kind expected under the fault-based accessed/dirty scheme
   function automatic ptc_fault_t efault(input logic [7:0] f, input ptc_acc_t a, input ptc_priv_t p,
                                         input logic pm);
      ptc_fault_t k;
      logic       ok;
      k  = (a == ACC_FETCH) ? FLT_FETCH : (a == ACC_LOAD || a == ACC_LOAD_RSV) ? FLT_LOAD : FLT_STORE;
      ok = f[0] && !(f[2] && !f[1]);
      ok = ok && ((k == FLT_FETCH) ? f[3] : (k == FLT_LOAD) ? f[1] : f[2]);
      ok = ok && ((p == PRIV_U) ? f[4] : (!f[4] || (pm && k != FLT_FETCH)));
      ok = ok && f[6] && (k != FLT_STORE || f[7]);
      return ok ? FLT_NONE : k;
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ====================
   // scenarios
   initial begin
      ptc_fault_t f;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      apb(1'b0, REG_CTRL, '0, 32'h0, 1'b0);
      apb(1'b0, 12'h010, '0, 32'h0, 1'b1);
      xl(32'hFFFF_F123, ACC_LOAD, PRIV_S, 1'b0, 34'h0_FFFF_F123, FLT_NONE);
      apb(1'b1, REG_ROOT, 32'h100, '0, 1'b0);
      apb(1'b0, REG_ROOT, '0, 32'h100, 1'b0);
      u_ptc32_mem_model.mem[L1A] = pte(22'h200, 8'h01);
      for (int i = 0; i < 8; i++) begin
         u_ptc32_mem_model.mem[L2A] = pte(22'h3ABCD, flg[i]);
         for (int m = 0; m < 2; m++) begin
            apb(1'b1, REG_CTRL, {30'h0, m[0], 1'b1}, '0, 1'b0);
            for (int p = 0; p < 2; p++) begin
               for (int a = 0; a < 6; a++) begin
                  f = efault(flg[i], ptc_acc_t'(a), ptc_priv_t'(p), m[0]);
                  xl(VA4K, ptc_acc_t'(a), ptc_priv_t'(p), 1'b0, (f == FLT_NONE) ? PA4K : '0, f);
               end
            end
         end
      end
      apb(1'b1, REG_CTRL, 32'h1, '0, 1'b0);
      xl(32'hFFFF_F123, ACC_STORE, PRIV_M, 1'b0, 34'h0_FFFF_F123, FLT_NONE);
      u_ptc32_mem_model.mem[L2A] = pte(22'h3ABCD, 8'h01);
      xl(VA4K, ACC_LOAD, PRIV_S, 1'b0, '0, FLT_LOAD);
      u_ptc32_mem_model.mem[L1A] = pte(22'h200, 8'h11);
      xl(VA4K, ACC_FETCH, PRIV_S, 1'b0, '0, FLT_FETCH);
      u_ptc32_mem_model.mem[L1A] = pte(22'h200, 8'h21);
      u_ptc32_mem_model.mem[L2A] = pte(22'h3ABCD, 8'hCB);
      xl(VA4K, ACC_FETCH, PRIV_S, 1'b0, PA4K, FLT_NONE);
      chk(rsp.global_map === 1'b1, "global mapping flag");
      u_ptc32_mem_model.mem[34'h10_00C0] = pte(22'h2AC00, 8'hC3);
      xl(32'h0C12_3456, ACC_LOAD, PRIV_S, 1'b0, {12'h0AB, 22'h12_3456}, FLT_NONE);
      u_ptc32_mem_model.mem[34'h10_00C0] = pte(22'h2AC01, 8'hC3);
      xl(32'h0C12_3456, ACC_LOAD, PRIV_S, 1'b0, '0, FLT_LOAD);
      // hardware accessed/dirty scheme with a slow memory and one lost swap
      apb(1'b1, REG_CTRL, 32'h7, '0, 1'b0);
      u_ptc32_mem_model.lat       = 3;
      u_ptc32_mem_model.fail_once = 1'b1;
      u_ptc32_mem_model.mem[L2A]  = pte(22'h3ABCD, 8'h0F);
      xl(VA4K, ACC_STORE, PRIV_S, 1'b0, PA4K, FLT_NONE);
      chk(u_ptc32_mem_model.mem[L2A] === pte(22'h3ABCD, 8'hCF), "entry after store");
      u_ptc32_mem_model.mem[L2A] = pte(22'h3ABCD, 8'h4F);
      xl(VA4K, ACC_STORE, PRIV_S, 1'b1, '0, FLT_NONE);
      chk(rsp.spec_blocked === 1'b1 && u_ptc32_mem_model.mem[L2A][7] === 1'b0, "speculative store");
      u_ptc32_mem_model.mem[L2A] = pte(22'h3ABCD, 8'h8F);
      xl(VA4K, ACC_LOAD, PRIV_S, 1'b0, PA4K, FLT_NONE);
      chk(u_ptc32_mem_model.mem[L2A] === pte(22'h3ABCD, 8'hCF), "dirty kept after load");
      xl(VA4K, ACC_LOAD_RSV, PRIV_S, 1'b0, PA4K, FLT_NONE);
      xl(VA4K, ACC_STORE_COND, PRIV_S, 1'b0, PA4K, FLT_NONE);
      chk(rsp.rsv_hit === 1'b1, "reservation same page");
      xl(VA4K, ACC_STORE_COND, PRIV_S, 1'b0, PA4K, FLT_NONE);
      chk(rsp.rsv_hit === 1'b0, "reservation consumed");
      // status: fault count, no reservation, last fault a load, level 0, global walk, idle
      apb(1'b0, REG_STATUS, '0, {flt_cnt[15:0], 11'h000, FLT_LOAD, 3'b010}, 1'b0);
      apb(1'b0, REG_FAULT_VA, '0, 32'h0C12_3456, 1'b0);
      conclude();
   end

   initial begin
      #2_000_000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
endmodule
